// *** pkg/supply_fault_pkg.sv ***
// constants and carrier types for the supply fault supervisor
package supply_fault_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned WAKE_ASSERT_US = 150;
	localparam int unsigned WAKE_RELEASE_MS = 1;
	localparam int unsigned SUPPLY_FILT_US = 200;
	localparam int unsigned SUPPLY_RELEASE_MS = 15;
	localparam int unsigned BATT_FILT_US = 64;
	localparam int unsigned PUMP_FILT_US = 64;
	localparam int unsigned THERM_DEGLITCH_US = 10;
	localparam int unsigned WAKE_ASSERT_CYC = WAKE_ASSERT_US * CLK_MHZ;
	localparam int unsigned WAKE_RELEASE_CYC = WAKE_RELEASE_MS * 1000 * CLK_MHZ;
	localparam int unsigned SUPPLY_FILT_CYC = SUPPLY_FILT_US * CLK_MHZ;
	localparam int unsigned SUPPLY_RELEASE_CYC = SUPPLY_RELEASE_MS * 1000 * CLK_MHZ;
	localparam int unsigned BATT_FILT_CYC = BATT_FILT_US * CLK_MHZ;
	localparam int unsigned PUMP_FILT_CYC = PUMP_FILT_US * CLK_MHZ;
	localparam int unsigned THERM_DEGLITCH_CYC = THERM_DEGLITCH_US * CLK_MHZ;
	localparam int unsigned LATCH_FAULT_LIMIT = 4;
	localparam int unsigned NUM_SUPPLY = 3;
	localparam int unsigned CNT_W = 21;
	localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;
	localparam logic [2:0] FCNT_ZERO = 3'h0;
	localparam logic [1:0] SYNC_RST = 2'h0;

	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_ACTIVE = 3'h1,
		MODE_SAFE = 3'h2,
		MODE_LATCH = 3'h3
	} mode_t;

	// comparator levels of one regulated output
	typedef struct packed {
		logic under;
		logic over;
	} supply_cmp_t;
endpackage

// *** src/supply_fault_supervisor.sv ***
// supervision of wake, regulated outputs, battery, charge pump and temperature
`timescale 1ns/100ps
`default_nettype none
module supply_fault_supervisor #(
	parameter int unsigned WAKE_RELEASE_CYC = supply_fault_pkg::WAKE_RELEASE_CYC,
	parameter int unsigned SUPPLY_RELEASE_CYC = supply_fault_pkg::SUPPLY_RELEASE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// comparator pins
	input wire logic wake_i,
	input wire supply_fault_pkg::supply_cmp_t [2:0] supply_cmp_i,
	input wire logic battery_supply_over_i,
	input wire logic battery_supply_under_i,
	input wire logic charge_pump_low_i,
	input wire logic temp_warn_high_i,
	input wire logic temp_warn_low_i,
	input wire logic thermal_shutdown_i,
	// watchdog verdict from the watchdog timer
	input wire logic watchdog_fail_i,
	// outputs to the host
	output logic primary_supply_reset_n_o,
	output logic secondary_supply_reset_n_o,
	output logic converter_supply_good_o,
	output logic thermal_warning_n_o,
	output logic watchdog_fault_out_o,
	output logic regulators_en_o,
	output supply_fault_pkg::mode_t mode_o
);
	localparam int unsigned NS = supply_fault_pkg::NUM_SUPPLY;
	localparam int unsigned CW = supply_fault_pkg::CNT_W;
	localparam logic [CW-1:0] WA_LIM = CW'(supply_fault_pkg::WAKE_ASSERT_CYC);
	localparam logic [CW-1:0] WR_LIM = CW'(WAKE_RELEASE_CYC);
	localparam logic [CW-1:0] SF_LIM = CW'(supply_fault_pkg::SUPPLY_FILT_CYC);
	localparam logic [CW-1:0] SR_LIM = CW'(SUPPLY_RELEASE_CYC);
	localparam logic [CW-1:0] BF_LIM = CW'(supply_fault_pkg::BATT_FILT_CYC);
	localparam logic [CW-1:0] PF_LIM = CW'(supply_fault_pkg::PUMP_FILT_CYC);
	localparam logic [CW-1:0] ONE = 21'h000001;
	localparam logic [2:0] FLIM = 3'(supply_fault_pkg::LATCH_FAULT_LIMIT);

	// two-stage synchronisers for all pin inputs
	localparam int unsigned NIN = 2 * NS + 8;
	logic [NIN-1:0] raw_w;
	logic [NIN-1:0] s1_r;
	logic [NIN-1:0] s2_r;
	assign raw_w = {supply_cmp_i, wake_i, battery_supply_over_i, battery_supply_under_i,
		charge_pump_low_i, temp_warn_high_i, temp_warn_low_i, thermal_shutdown_i, watchdog_fail_i};
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_r <= '0;
			s2_r <= '0;
		end else if (clk_en_i) begin
			s1_r <= raw_w;
			s2_r <= s1_r;
		end
	end
	logic wake_s, bov_s, buv_s, cp_s, twh_s, twl_s, tsd_s, wdf_s;
	logic [2*NS-1:0] sup_s;
	assign {sup_s, wake_s, bov_s, buv_s, cp_s, twh_s, twl_s, tsd_s, wdf_s} = s2_r;

	// wake qualification, separate assert and release delays
	logic wake_q_r;
	logic [CW-1:0] wake_cnt_r;
	logic wake_diff_w;
	logic [CW-1:0] wake_lim_w;
	assign wake_diff_w = wake_s != wake_q_r;
	assign wake_lim_w = wake_q_r ? WR_LIM : WA_LIM;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wake_q_r <= 1'b0;
			wake_cnt_r <= supply_fault_pkg::CNT_ZERO;
		end else if (clk_en_i) begin
			if (!wake_diff_w) begin
				wake_cnt_r <= supply_fault_pkg::CNT_ZERO;
			end else if (wake_cnt_r >= wake_lim_w - ONE) begin
				wake_q_r <= wake_s;
				wake_cnt_r <= supply_fault_pkg::CNT_ZERO;
			end else begin
				wake_cnt_r <= wake_cnt_r + ONE;
			end
		end
	end

	// supply monitors: filter, then release delay
	logic [NS-1:0] good_r;
	logic [NS-1:0] up_r;
	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sup
			logic bad_w;
			logic [CW-1:0] filt_r;
			logic [CW-1:0] rel_r;
			logic faulted_r;
			assign bad_w = sup_s[2*g+1] | sup_s[2*g];
			always_ff @(posedge clk_i or posedge reset_i) begin
				if (reset_i) begin
					filt_r <= supply_fault_pkg::CNT_ZERO;
					rel_r <= supply_fault_pkg::CNT_ZERO;
					faulted_r <= 1'b1;
					good_r[g] <= 1'b0;
					up_r[g] <= 1'b0;
				end else if (clk_en_i) begin
					if (!wake_q_r || !regulators_en_o) begin
						// held low until its own output rises again
						faulted_r <= 1'b1;
						good_r[g] <= 1'b0;
						up_r[g] <= 1'b0;
						filt_r <= supply_fault_pkg::CNT_ZERO;
						rel_r <= supply_fault_pkg::CNT_ZERO;
					end else if (!up_r[g]) begin
						if (!sup_s[2*g+1]) begin
							up_r[g] <= 1'b1;
							faulted_r <= 1'b0;
							good_r[g] <= 1'b1;
						end
					end else if (!bad_w) begin
						filt_r <= supply_fault_pkg::CNT_ZERO;
						if (faulted_r) begin
							if (rel_r >= SR_LIM - ONE) begin
								faulted_r <= 1'b0;
								good_r[g] <= 1'b1;
								rel_r <= supply_fault_pkg::CNT_ZERO;
							end else begin
								rel_r <= rel_r + ONE;
							end
						end
					end else begin
						rel_r <= supply_fault_pkg::CNT_ZERO;
						if (faulted_r) begin
							good_r[g] <= 1'b0;
						end else if (filt_r >= SF_LIM - ONE) begin
							faulted_r <= 1'b1;
							good_r[g] <= 1'b0;
						end else begin
							filt_r <= filt_r + ONE;
						end
					end
				end
			end
		end
	endgenerate

	// battery and charge pump filters with enter and exit qualification
	logic batt_flt_r, cp_flt_r;
	logic [CW-1:0] batt_cnt_r, cp_cnt_r;
	logic batt_cond_w, cp_cond_w;
	assign batt_cond_w = batt_flt_r ? !(bov_s | buv_s) : (bov_s | buv_s);
	assign cp_cond_w = cp_flt_r ? !cp_s : cp_s;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			batt_flt_r <= 1'b0;
			batt_cnt_r <= supply_fault_pkg::CNT_ZERO;
		end else if (clk_en_i) begin
			if (!batt_cond_w) begin
				batt_cnt_r <= supply_fault_pkg::CNT_ZERO;
			end else if (batt_cnt_r >= BF_LIM - ONE) begin
				batt_flt_r <= !batt_flt_r;
				batt_cnt_r <= supply_fault_pkg::CNT_ZERO;
			end else begin
				batt_cnt_r <= batt_cnt_r + ONE;
			end
		end
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cp_flt_r <= 1'b0;
			cp_cnt_r <= supply_fault_pkg::CNT_ZERO;
		end else if (clk_en_i) begin
			if (!cp_cond_w) begin
				cp_cnt_r <= supply_fault_pkg::CNT_ZERO;
			end else if (cp_cnt_r >= PF_LIM - ONE) begin
				cp_flt_r <= !cp_flt_r;
				cp_cnt_r <= supply_fault_pkg::CNT_ZERO;
			end else begin
				cp_cnt_r <= cp_cnt_r + ONE;
			end
		end
	end

	// thermal warning with hysteresis and shutdown hold
	logic tw_r, tsd_hold_r;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tw_r <= 1'b0;
			tsd_hold_r <= 1'b0;
		end else if (clk_en_i) begin
			if (twh_s) begin
				tw_r <= 1'b1;
			end else if (!twl_s) begin
				tw_r <= 1'b0;
			end
			if (tsd_s) begin
				tsd_hold_r <= 1'b1;
			end else if (!twl_s) begin
				tsd_hold_r <= 1'b0;
			end
		end
	end

	// mode sequencing and latch-state fault counting
	supply_fault_pkg::mode_t mode_r, mode_nxt;
	logic [2:0] fcnt_r;
	logic cp_flt_d_r, tsd_d_r, wdf_d_r;
	logic safe_w, rep_evt_w;
	assign safe_w = batt_flt_r | cp_flt_r | tsd_hold_r;
	// rising edges of the faults that count toward latch
	assign rep_evt_w = (cp_flt_r & !cp_flt_d_r) | (tsd_hold_r & !tsd_d_r) | (wdf_s & !wdf_d_r);
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			supply_fault_pkg::MODE_OFF: begin
				if (wake_q_r) begin
					mode_nxt = safe_w ? supply_fault_pkg::MODE_SAFE : supply_fault_pkg::MODE_ACTIVE;
				end
			end
			supply_fault_pkg::MODE_ACTIVE: begin
				if (safe_w) begin
					mode_nxt = supply_fault_pkg::MODE_SAFE;
				end
			end
			supply_fault_pkg::MODE_SAFE: begin
				if (!safe_w) begin
					mode_nxt = supply_fault_pkg::MODE_ACTIVE;
				end
			end
			supply_fault_pkg::MODE_LATCH: mode_nxt = supply_fault_pkg::MODE_LATCH;
			default: mode_nxt = supply_fault_pkg::MODE_OFF;
		endcase
		if (rep_evt_w && fcnt_r >= FLIM - 3'h1 && mode_r != supply_fault_pkg::MODE_OFF) begin
			mode_nxt = supply_fault_pkg::MODE_LATCH;
		end
		if (!wake_q_r) begin
			mode_nxt = supply_fault_pkg::MODE_OFF;
		end
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_r <= supply_fault_pkg::MODE_OFF;
			fcnt_r <= supply_fault_pkg::FCNT_ZERO;
			cp_flt_d_r <= 1'b0;
			tsd_d_r <= 1'b0;
			wdf_d_r <= 1'b0;
		end else if (clk_en_i) begin
			mode_r <= mode_nxt;
			cp_flt_d_r <= cp_flt_r;
			tsd_d_r <= tsd_hold_r;
			wdf_d_r <= wdf_s;
			if (!wake_q_r) begin
				fcnt_r <= supply_fault_pkg::FCNT_ZERO;
			end else if (rep_evt_w && fcnt_r < FLIM) begin
				fcnt_r <= fcnt_r + 3'h1;
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			primary_supply_reset_n_o <= 1'b0;
			secondary_supply_reset_n_o <= 1'b0;
			converter_supply_good_o <= 1'b0;
			thermal_warning_n_o <= 1'b1;
			watchdog_fault_out_o <= 1'b1;
			regulators_en_o <= 1'b0;
			mode_o <= supply_fault_pkg::MODE_OFF;
		end else if (clk_en_i) begin
			primary_supply_reset_n_o <= good_r[0];
			secondary_supply_reset_n_o <= good_r[1];
			converter_supply_good_o <= good_r[2];
			thermal_warning_n_o <= !(tw_r && wake_q_r);
			watchdog_fault_out_o <= !(wdf_s || mode_r == supply_fault_pkg::MODE_LATCH);
			regulators_en_o <= mode_nxt == supply_fault_pkg::MODE_ACTIVE;
			mode_o <= mode_r;
		end
	end

	// checks
	sequence fault_held_s;
		!good_r[0] ##1 !good_r[0];
	endsequence
	wake_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
		clk_en_i && !wake_q_r |=> mode_r == supply_fault_pkg::MODE_OFF)
		else $error("mode not off without wake");
	reg_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
		clk_en_i && safe_w |=> !regulators_en_o)
		else $error("regulators on during fault");
	latch_stay_a: assert property (@(posedge clk_i) disable iff (reset_i)
		mode_r == supply_fault_pkg::MODE_LATCH && wake_q_r |=> mode_r == supply_fault_pkg::MODE_LATCH)
		else $error("latch state left");
	prim_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
		clk_en_i |=> primary_supply_reset_n_o == $past(good_r[0]))
		else $error("primary reset mismatch");
	sec_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
		clk_en_i && !regulators_en_o |=> ##1 !secondary_supply_reset_n_o || !clk_en_i)
		else $error("secondary reset not held");
	wd_out_a: assert property (@(posedge clk_i) disable iff (reset_i)
		clk_en_i && wdf_s |=> !watchdog_fault_out_o)
		else $error("watchdog fault not shown");
	refault_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
		g_sup[0].faulted_r && up_r[0] && sup_s[0] && clk_en_i |=> !good_r[0])
		else $error("release during refault");
	filt_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
		clk_en_i && !batt_cond_w |=> batt_cnt_r == supply_fault_pkg::CNT_ZERO)
		else $error("battery filter not cleared");
	warn_hyst_a: assert property (@(posedge clk_i) disable iff (reset_i)
		clk_en_i && tw_r && twl_s && !twh_s |=> tw_r)
		else $error("warning released inside hysteresis");
endmodule
`default_nettype wire

// *** verif/host_model.sv ***
// host side: counts releases of the primary reset it receives
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// primary reset line from the supervisor
	input wire logic primary_supply_reset_n_i,
	// releases seen
	output logic [7:0] release_count_o
);
	logic last_r;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			last_r <= 1'h0;
			release_count_o <= 8'h00;
		end else begin
			last_r <= primary_supply_reset_n_i;
			if (primary_supply_reset_n_i && !last_r) begin
				release_count_o <= release_count_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/tb_supply_fault_supervisor.sv ***
// self-checking bench for the supply fault supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_supply_fault_supervisor;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic wake_i = 1'h0;
	supply_fault_pkg::supply_cmp_t [2:0] sup = 6'h2a;
	logic bat_over = 1'h0;
	logic bat_under = 1'h0;
	logic pump_low = 1'h0;
	logic warn_high = 1'h0;
	logic warn_low = 1'h0;
	logic thermal_shutdown = 1'h0;
	logic wd_fail = 1'h0;
	logic clk_en = 1'h1;
	logic rst1_n, rst2_n, adc_good, thermal_warning_n, watchdog_fault_out, reg_en;
	supply_fault_pkg::mode_t mode_o;
	logic [7:0] releases;
	int mismatches = 0;
	int tests_run = 0;
	always #5 clk_i = ~clk_i;
	// short release counts keep the run bounded
	supply_fault_supervisor #(.WAKE_RELEASE_CYC(50), .SUPPLY_RELEASE_CYC(200)) u_supply_fault_supervisor (
		.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en), .wake_i(wake_i), .supply_cmp_i(sup),
		.battery_supply_over_i(bat_over), .battery_supply_under_i(bat_under),
		.charge_pump_low_i(pump_low), .temp_warn_high_i(warn_high), .temp_warn_low_i(warn_low),
		.thermal_shutdown_i(thermal_shutdown), .watchdog_fail_i(wd_fail), .primary_supply_reset_n_o(rst1_n),
		.secondary_supply_reset_n_o(rst2_n), .converter_supply_good_o(adc_good),
		.thermal_warning_n_o(thermal_warning_n), .watchdog_fault_out_o(watchdog_fault_out), .regulators_en_o(reg_en), .mode_o(mode_o));
	host_model u_host_model (.clk_i(clk_i), .reset_i(reset_i), .primary_supply_reset_n_i(rst1_n),
		.release_count_o(releases));
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		@(negedge clk_i);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
		// back on the rising edge so the next stimulus lands there
		@(posedge clk_i);
	endtask
	task automatic wait_mode(input supply_fault_pkg::mode_t m, input int lim);
		int n;
		n = 0;
		@(negedge clk_i);
		while (mode_o !== m && n < lim) begin
			@(negedge clk_i);
			n++;
		end
		check(8'(mode_o), 8'(m));
	endtask
	task automatic wake_up();
		wake_i <= 1'h1;
		tick(14900);
		check(8'(mode_o), 8'h00);
		wait_mode(supply_fault_pkg::MODE_ACTIVE, 200);
		check({rst1_n, rst2_n, adc_good}, 8'h00);
		tick(1);
		sup <= 6'h00;
		tick(10);
		check({rst1_n, rst2_n, adc_good}, 8'h07);
	endtask
	task automatic supply_faults();
		sup[0].over <= 1'h1;
		tick(19000);
		check(rst1_n, 8'h01);
		sup <= 6'h00;
		tick(1);
		sup <= 6'h2e;
		tick(19980);
		check({rst1_n, rst2_n, adc_good}, 8'h07);
		tick(30);
		check({rst1_n, rst2_n, adc_good}, 8'h00);
		sup <= 6'h00;
		tick(100);
		sup[0].under <= 1'h1;
		tick(10);
		sup <= 6'h00;
		tick(150);
		check({rst1_n, rst2_n, adc_good}, 8'h03);
		tick(60);
		check(rst1_n, 8'h01);
		check(releases, 8'h02);
	endtask
	task automatic filt_safe(input int which);
		if (which == 0) bat_over <= 1'h1;
		else pump_low <= 1'h1;
		tick(6300);
		check(8'(mode_o), 8'h01);
		wait_mode(supply_fault_pkg::MODE_SAFE, 200);
		check(reg_en, 8'h00);
		bat_over <= 1'h0;
		pump_low <= 1'h0;
		tick(6300);
		check(8'(mode_o), 8'h02);
		wait_mode(supply_fault_pkg::MODE_ACTIVE, 200);
	endtask
	task automatic thermal();
		warn_low <= 1'h1;
		warn_high <= 1'h1;
		tick(5);
		check(thermal_warning_n, 8'h00);
		warn_high <= 1'h0;
		tick(20);
		check(thermal_warning_n, 8'h00);
		thermal_shutdown <= 1'h1;
		wait_mode(supply_fault_pkg::MODE_SAFE, 2000);
		thermal_shutdown <= 1'h0;
		tick(50);
		check(8'(mode_o), 8'h02);
		warn_low <= 1'h0;
		tick(5);
		check(thermal_warning_n, 8'h01);
		wait_mode(supply_fault_pkg::MODE_ACTIVE, 2000);
	endtask
	task automatic freeze();
		clk_en <= 1'h0;
		warn_high <= 1'h1;
		warn_low <= 1'h1;
		tick(10);
		check(thermal_warning_n, 8'h01);
		clk_en <= 1'h1;
		tick(5);
		check(thermal_warning_n, 8'h00);
		warn_high <= 1'h0;
		warn_low <= 1'h0;
		tick(5);
		check(thermal_warning_n, 8'h01);
	endtask
	task automatic watchdog_latch();
		wd_fail <= 1'h1;
		tick(5);
		check(watchdog_fault_out, 8'h00);
		wd_fail <= 1'h0;
		tick(5);
		check(watchdog_fault_out, 8'h01);
		wd_fail <= 1'h1;
		// pump, shutdown and two watchdog events make four
		wait_mode(supply_fault_pkg::MODE_LATCH, 20);
		wd_fail <= 1'h0;
		tick(10);
		check(watchdog_fault_out, 8'h00);
		wake_i <= 1'h0;
		tick(40);
		check(8'(mode_o), 8'h03);
		wait_mode(supply_fault_pkg::MODE_OFF, 40);
	endtask
	task automatic wrap_up();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		tick(8);
		reset_i <= 1'h0;
		check(8'(mode_o), 8'h00);
		wake_up();
		supply_faults();
		filt_safe(0);
		filt_safe(1);
		thermal();
		freeze();
		watchdog_latch();
		wrap_up();
	end
	initial begin
		tick(95000);
		mismatches++;
		wrap_up();
	end
endmodule
`default_nettype wire
